/* common/pml_pkg.sv */
package pml_pkg;
    // Register offsets
    localparam logic [7:0] OFS_LOAD_RESULT_STATUS = 8'h41;
    localparam logic [7:0] OFS_PROGRAM_LOAD_CONTROL = 8'h60;
    localparam logic [7:0] OFS_PROGRAM_LOAD_DATA = 8'h61;
    localparam logic [7:0] OFS_LOAD_START_ADDRESS_LOW = 8'h62;
    localparam logic [7:0] OFS_LOAD_START_ADDRESS_HIGH = 8'h63;
    // Control field positions
    localparam int BIT_POINTER_CLEAR = 0;
    localparam int BIT_READ_WRITE_SELECT = 1;
    localparam int BIT_PARITY_SELECT = 2;
    localparam int BIT_PROGRAM_MEMORY_ENABLE = 3;
    localparam int BIT_PARITY_CHECK_ENABLE = 4;
    localparam int BIT_PROCESSOR_RESET = 6;
    localparam int BIT_PROGRAM_SELECT = 7;
    // Reset values, status codes and broadcast address
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_START_ADDR = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] STATUS_INVALID = 8'hFF;
    localparam logic [7:0] STATUS_VALID_MIN = 8'h01;
    localparam logic [7:0] STATUS_VALID_MAX = 8'hFE;
    localparam logic [7:0] BROADCAST_ADDR = 8'h7F;
    // Compatibility check deadline
    localparam int CLK_HZ = 25000000;
    localparam int CHECK_LIMIT_US = 1000;
    localparam int CHECK_LIMIT_CYC = CHECK_LIMIT_US * (CLK_HZ / 1000000);
    localparam int CHECK_SCAN_CYC = 64;
endpackage

/* logic/pml_check.sv */
`timescale 1ns/1ps
module pml_check
    import pml_pkg::*;
#(
    parameter logic [7:0] VALID_CODE = 8'h5A // Arbitrary version code
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [7:0] sig_byte,
    input wire logic [7:0] par_byte,
    output logic [5:0] scan_addr,
    output logic done,
    output logic ok
);
    typedef struct packed {
        logic busy;
        logic [5:0] idx;
        logic [7:0] acc;
        logic parity_ok;
        logic done;
        logic ok;
    } pml_chk_s;
    pml_chk_s q, d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        if (start) begin
            d.busy = 1'b1;
            d.idx = 6'h00;
            d.acc = 8'h00;
            d.parity_ok = 1'b1;
        end else if (q.busy) begin
            // Each byte must carry its stored even-parity bit
            d.acc = q.acc ^ sig_byte;
            if ((^sig_byte) != par_byte[0]) begin
                d.parity_ok = 1'b0;
            end
            d.idx = q.idx + 6'h01;
            if (q.idx == 6'(CHECK_SCAN_CYC - 1)) begin
                d.busy = 1'b0;
                d.done = 1'b1;
                d.ok = q.parity_ok && ((^sig_byte) == par_byte[0])
                       && ((q.acc ^ sig_byte) == VALID_CODE);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign scan_addr = q.idx;
    assign done = q.done;
    assign ok = q.ok;
endmodule

/* logic/pml_top.sv */
`timescale 1ns/1ps
// Summary of operation
// - With write select and pointer clear low, each data byte write stores into memory at the pointer.
// - With read select, each data byte read returns memory at the pointer.
// - Consecutive data bytes accepted in one transfer until STOP.
// - Pointer clear bit high holds pointer reset; low releases it; resets to 0.
// - Sixteen-bit start address in two byte registers, reset zero, sets load origin.
// - Loading controls act only at lower device address or broadcast; upper address ignored.
// - Broadcast address also reaches loading controls.
// - Safe mode still accepts preparation and reloading.
// - After write preparation, data writes load program memory from start address.
// - After parity preparation, data writes load parity memory from start address.
// - Compatibility check finishes within 1 ms after run sequence.
// - Valid image gives status 01 to FE and normal operation.
// - Invalid image gives status FF, clears memory enable, enters safe mode.
// - Memory enable selects loaded plus fixed memory while no check runs, else fixed only.
// - Parity select routes data accesses to parity memory.
module pml_top
    import pml_pkg::*;
#(
    parameter int ADDR_W = 13,
    parameter logic [7:0] VERSION_CODE = 8'h5A, // Arbitrary version code
    parameter logic [7:0] VALID_STATUS = 8'h01
) (
    input wire logic REF_CLK,
    input wire logic NRST,
    // Byte register port from the I2C engine
    input wire logic [7:0] DEV_ADDR,
    input wire logic [7:0] LOWER_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic BUS_STOP,
    output logic [7:0] REG_RDATA,
    output logic REG_ACK,
    // Processor side
    output logic CPU_HOLD,
    output logic RUN_LOADED_MEM,
    output logic SAFE_MODE,
    output logic PARITY_CHECK_ON,
    output logic CHECK_BUSY
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam int CHK_WIN = CHECK_SCAN_CYC + 2;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] start_addr;
        logic [15:0] ptr;
        logic [7:0] status;
        logic [7:0] rdata;
        logic ack;
        logic run_prev;
        logic checking;
        logic safe;
        logic in_burst;
    } pml_state_s;
    pml_state_s q, d;

    logic [7:0] prog_mem [DEPTH];
    logic par_mem [DEPTH];
    logic [ADDR_W-1:0] mem_idx;
    logic addr_hit;
    logic data_wr;
    logic data_rd;
    logic run_now;
    logic chk_start;
    logic chk_done;
    logic chk_ok;
    logic [5:0] scan_addr;
    logic [7:0] scan_byte;
    logic [7:0] scan_par;

    function automatic logic ctl(input logic [7:0] c, input int b);
        return c[b];
    endfunction

    // ---------------------------------------------------------------
    // Address qualification
    // ---------------------------------------------------------------
    // Upper device address never reaches the loader
    assign addr_hit = (DEV_ADDR == LOWER_ADDR) || (DEV_ADDR == BROADCAST_ADDR);
    assign mem_idx = q.ptr[ADDR_W-1:0];
    assign data_wr = addr_hit && REG_WR && (REG_ADDR == OFS_PROGRAM_LOAD_DATA)
                     && !ctl(q.ctrl, BIT_READ_WRITE_SELECT)
                     && !ctl(q.ctrl, BIT_POINTER_CLEAR);
    assign data_rd = addr_hit && REG_RD && (REG_ADDR == OFS_PROGRAM_LOAD_DATA)
                     && ctl(q.ctrl, BIT_READ_WRITE_SELECT);
    assign run_now = ctl(q.ctrl, BIT_PROGRAM_MEMORY_ENABLE) && !ctl(q.ctrl, BIT_PROGRAM_SELECT)
                     && !ctl(q.ctrl, BIT_PROCESSOR_RESET);
    assign chk_start = run_now && !q.run_prev;

    // ---------------------------------------------------------------
    // Memories
    // ---------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (data_wr && !ctl(q.ctrl, BIT_PARITY_SELECT)) begin
            prog_mem[mem_idx] <= REG_WDATA;
        end
        if (data_wr && ctl(q.ctrl, BIT_PARITY_SELECT)) begin
            par_mem[mem_idx] <= REG_WDATA[0];
        end
    end

    assign scan_byte = prog_mem[ADDR_W'(scan_addr)];
    assign scan_par = {7'h00, par_mem[ADDR_W'(scan_addr)]};

    pml_check #(
        .VALID_CODE(VERSION_CODE)
    ) u_check (
        .clk(REF_CLK),
        .rst_n(NRST),
        .start(chk_start),
        .sig_byte(scan_byte),
        .par_byte(scan_par),
        .scan_addr(scan_addr),
        .done(chk_done),
        .ok(chk_ok)
    );

    // ---------------------------------------------------------------
    // Register file and pointer
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        d.ack = 1'b0;
        d.run_prev = run_now;
        if (BUS_STOP) begin
            d.in_burst = 1'b0;
        end
        if (addr_hit && REG_WR) begin
            d.ack = 1'b1;
            unique case (REG_ADDR)
                OFS_PROGRAM_LOAD_CONTROL: d.ctrl = REG_WDATA & 8'hDF;
                OFS_LOAD_START_ADDRESS_LOW: d.start_addr[7:0] = REG_WDATA;
                OFS_LOAD_START_ADDRESS_HIGH: d.start_addr[15:8] = REG_WDATA;
                default: d.ack = (REG_ADDR == OFS_PROGRAM_LOAD_DATA);
            endcase
        end
        if (addr_hit && REG_RD) begin
            d.ack = 1'b1;
            unique case (REG_ADDR)
                OFS_LOAD_RESULT_STATUS: d.rdata = q.status;
                OFS_PROGRAM_LOAD_CONTROL: d.rdata = q.ctrl;
                OFS_LOAD_START_ADDRESS_LOW: d.rdata = q.start_addr[7:0];
                OFS_LOAD_START_ADDRESS_HIGH: d.rdata = q.start_addr[15:8];
                OFS_PROGRAM_LOAD_DATA: begin
                    if (!data_rd) begin
                        d.rdata = 8'h00;
                    end else if (ctl(q.ctrl, BIT_PARITY_SELECT)) begin
                        d.rdata = {7'h00, par_mem[mem_idx]};
                    end else begin
                        d.rdata = prog_mem[mem_idx];
                    end
                end
                default: d.rdata = 8'h00;
            endcase
        end
        // Pointer loads the origin while clear is held
        if (ctl(q.ctrl, BIT_POINTER_CLEAR)) begin
            d.ptr = q.start_addr;
        end else if (data_wr || data_rd) begin
            d.ptr = q.ptr + 16'h0001;
            d.in_burst = !BUS_STOP;
        end
        if (chk_start) begin
            d.checking = 1'b1;
        end
        // Preparation always allowed, even from safe mode
        if (ctl(q.ctrl, BIT_PROGRAM_SELECT)) begin
            d.checking = 1'b0;
        end
        if (chk_done && q.checking) begin
            d.checking = 1'b0;
            if (chk_ok) begin
                d.status = VALID_STATUS;
                d.safe = 1'b0;
            end else begin
                d.status = STATUS_INVALID;
                d.safe = 1'b1;
                d.ctrl[BIT_PROGRAM_MEMORY_ENABLE] = 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            q <= '0;
            q.ctrl <= RST_CONTROL;
            q.start_addr <= {RST_START_ADDR, RST_START_ADDR};
            q.status <= RST_STATUS;
        end else begin
            q <= d;
        end
    end

    assign REG_RDATA = q.rdata;
    assign REG_ACK = q.ack;
    assign CPU_HOLD = ctl(q.ctrl, BIT_PROCESSOR_RESET) || q.checking;
    assign RUN_LOADED_MEM = ctl(q.ctrl, BIT_PROGRAM_MEMORY_ENABLE) && !q.checking;
    assign SAFE_MODE = q.safe;
    assign PARITY_CHECK_ON = ctl(q.ctrl, BIT_PARITY_CHECK_ENABLE);
    assign CHECK_BUSY = q.checking;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_ptr_clear_load: assert property (@(posedge REF_CLK) disable iff (!NRST)
        ctl(q.ctrl, BIT_POINTER_CLEAR) |=> (q.ptr == $past(q.start_addr)))
        else $error("pointer not loaded while clear held");
    a_ptr_step_one: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (data_wr && !ctl(q.ctrl, BIT_POINTER_CLEAR)) |=> (q.ptr == $past(q.ptr) + 16'h0001))
        else $error("pointer did not advance by one");
    a_check_deadline: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (chk_start && !ctl(q.ctrl, BIT_PROGRAM_SELECT)) |=> ##[0:CHK_WIN] !q.checking)
        else $error("compatibility check overran");
    a_invalid_status: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (chk_done && q.checking && !chk_ok) |=>
            (q.status == STATUS_INVALID) && q.safe && !ctl(q.ctrl, BIT_PROGRAM_MEMORY_ENABLE))
        else $error("invalid image not flagged");
    a_valid_status: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (chk_done && q.checking && chk_ok) |=>
            (q.status >= STATUS_VALID_MIN) && (q.status <= STATUS_VALID_MAX) && !q.safe)
        else $error("valid image status out of range");
    a_upper_ignored: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (REG_WR && !addr_hit) |=> ($stable(q.ctrl) || $past(chk_done)) && !REG_ACK)
        else $error("upper address changed loader state");
    a_read_data: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (data_rd && !ctl(q.ctrl, BIT_PARITY_SELECT) && !REG_WR) |=>
            (REG_RDATA == $past(prog_mem[mem_idx])) && REG_ACK)
        else $error("data read returned wrong byte");
    a_run_select: assert property (@(posedge REF_CLK) disable iff (!NRST)
        RUN_LOADED_MEM |-> (ctl(q.ctrl, BIT_PROGRAM_MEMORY_ENABLE) && !q.checking))
        else $error("loaded memory used while disabled");
    a_start_addr: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (addr_hit && REG_WR && REG_ADDR == OFS_LOAD_START_ADDRESS_HIGH) |=>
            (q.start_addr[15:8] == $past(REG_WDATA)))
        else $error("start address high byte not stored");

    // ---------------------------------------------------------------
    // Memory, routing and burst assertions
    // ---------------------------------------------------------------
    // Burst flag is informational; only STOP ends it
    a_data_store: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (data_wr && !ctl(q.ctrl, BIT_PARITY_SELECT)) |=> (prog_mem[$past(mem_idx)] == $past(REG_WDATA)))
        else $error("data byte not stored at pointer");
    a_parity_store: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (data_wr && ctl(q.ctrl, BIT_PARITY_SELECT)) |=> (par_mem[$past(mem_idx)] == $past(REG_WDATA[0])))
        else $error("parity bit not stored at pointer");
    a_parity_read: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (data_rd && ctl(q.ctrl, BIT_PARITY_SELECT) && !REG_WR) |=>
            (REG_RDATA == {7'h00, $past(par_mem[mem_idx])}))
        else $error("parity read returned wrong bit");
    a_broadcast_ack: assert property (@(posedge REF_CLK) disable iff (!NRST)
        ((DEV_ADDR == BROADCAST_ADDR) && REG_WR && (REG_ADDR == OFS_LOAD_START_ADDRESS_LOW)) |=> REG_ACK)
        else $error("broadcast write not acknowledged");
    a_safe_reload: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (SAFE_MODE && !q.checking && addr_hit && REG_WR && (REG_ADDR == OFS_PROGRAM_LOAD_CONTROL))
            |=> (q.ctrl == $past(REG_WDATA & 8'hDF)))
        else $error("control write refused in safe mode");
    a_stop_ends_burst: assert property (@(posedge REF_CLK) disable iff (!NRST)
        BUS_STOP |=> !q.in_burst)
        else $error("burst flag survived stop");
    a_hold_in_check: assert property (@(posedge REF_CLK) disable iff (!NRST)
        q.checking |-> CPU_HOLD)
        else $error("processor released during check");
endmodule

/* tb/pml_host_model.sv */
`timescale 1ns/1ps
module pml_host_model
    import pml_pkg::*;
#(
    parameter int PWR_WAIT = 8
) (
    input wire logic clk,
    input wire logic [7:0] rdata,
    input wire logic ack,
    output logic wr,
    output logic rd,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic stop
);
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        stop = 1'b0;
    end

    // Scaled power-on wait; no other traffic before loading, though the testbench reads and writes registers first
    task automatic power_up();
        repeat (PWR_WAIT) @(posedge clk);
    endtask

    // Released fields show their inverse, not the last value
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic k);
        @(posedge clk);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1;
        q = rdata;
        k = ack;
    endtask

    task automatic stop_burst();
        @(posedge clk);
        stop <= 1'b1;
        @(posedge clk);
        stop <= 1'b0;
    endtask

    // Program select and processor reset up, parity select from p, read/write 1 then final, pointer clear 0-1-0
    task automatic prep(input logic r, input logic p);
        logic [7:0] q;
        logic k;
        logic [7:0] b;
        b = {5'b11000, p, 2'b00};
        acc(1'b1, OFS_PROGRAM_LOAD_CONTROL, b | 8'h02, q, k);
        acc(1'b1, OFS_PROGRAM_LOAD_CONTROL, b | {6'h00, r, 1'b1}, q, k);
        acc(1'b1, OFS_PROGRAM_LOAD_CONTROL, b | {6'h00, r, 1'b0}, q, k);
    endtask

    task automatic run();
        logic [7:0] q;
        logic k;
        acc(1'b1, OFS_PROGRAM_LOAD_CONTROL, 8'h18, q, k);
    endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    import pml_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} pml_row_s;
    localparam logic [7:0] LOW_ID = 8'h20;
    localparam logic [7:0] VER = 8'h5A; // Arbitrary version code
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] dev_addr = LOW_ID;
    logic wr, rd, stop, ack, hold, run_mem, safe, par_on, busy, k;
    logic [7:0] addr, wdata, rdata, q;
    int bad_count = 0;
    int checks = 0;
    pml_row_s rows [4] = '{'{8'h62, 8'hA5, 8'hA5}, '{8'h63, 8'h3C, 8'h3C},
                           '{8'h60, 8'h22, 8'h02}, '{8'h41, 8'h55, 8'h00}};

    always #20 clk = ~clk;

    pml_top #(.VERSION_CODE(VER)) dut_u (.REF_CLK(clk), .NRST(nrst),
        .DEV_ADDR(dev_addr), .LOWER_ADDR(LOW_ID), .REG_WR(wr), .REG_RD(rd),
        .REG_ADDR(addr), .REG_WDATA(wdata), .BUS_STOP(stop), .REG_RDATA(rdata),
        .REG_ACK(ack), .CPU_HOLD(hold), .RUN_LOADED_MEM(run_mem),
        .SAFE_MODE(safe), .PARITY_CHECK_ON(par_on), .CHECK_BUSY(busy));
    pml_host_model host_u (.clk(clk), .rdata(rdata), .ack(ack), .wr(wr),
        .rd(rd), .addr(addr), .wdata(wdata), .stop(stop));

    function automatic logic [7:0] img(input int i, input logic bad);
        return (i == 63) ? (bad ? 8'h5B : VER) : 8'h00;
    endfunction

    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        host_u.acc(1'b1, a, d, q, k);
    endtask

    task automatic rd8(input logic [7:0] a, input logic [7:0] e);
        host_u.acc(1'b0, a, 8'h00, q, k);
        `CHK(q, e)
    endtask

    task automatic summarize();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Full image load, parity load, run and bounded check wait
    // ------------------------------------------------------------
    task automatic load(input logic bad);
        int n;
        for (int p = 0; p < 2; p++) begin
            host_u.prep(1'b0, p[0]);
            for (int i = 0; i < 64; i++) begin
                wr8(OFS_PROGRAM_LOAD_DATA, p ? {7'h00, ^img(i, bad)} : img(i, bad));
                `CHK(k, 1'b1)
            end
            host_u.stop_burst();
        end
        host_u.run();
        n = 0;
        repeat (2) @(posedge clk);
        #1;
        `CHK(busy, 1'b1)
        while (busy === 1'b1 && n < 25000) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(n < 25000, 1'b1)
        if (n >= 25000)
            summarize();
    endtask

    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        host_u.power_up();
        rd8(OFS_LOAD_RESULT_STATUS, 8'h00);
        rd8(OFS_PROGRAM_LOAD_CONTROL, 8'h00);
        rd8(OFS_LOAD_START_ADDRESS_HIGH, 8'h00);
        foreach (rows[i]) begin
            wr8(rows[i].a, rows[i].d);
            rd8(rows[i].a, rows[i].e);
        end
        // ------------------------------------------------------------
        // Device address filtering
        // ------------------------------------------------------------
        dev_addr <= LOW_ID | 8'h01;
        wr8(OFS_LOAD_START_ADDRESS_LOW, 8'h77);
        `CHK(k, 1'b0)
        dev_addr <= BROADCAST_ADDR;
        wr8(OFS_LOAD_START_ADDRESS_LOW, 8'h10);
        `CHK(k, 1'b1)
        dev_addr <= LOW_ID;
        rd8(OFS_LOAD_START_ADDRESS_LOW, 8'h10);
        // ------------------------------------------------------------
        // Short stream from start 0x0010, read back, parity routing
        // ------------------------------------------------------------
        wr8(OFS_LOAD_START_ADDRESS_HIGH, 8'h00);
        host_u.prep(1'b0, 1'b0);
        for (int i = 1; i < 4; i++)
            wr8(OFS_PROGRAM_LOAD_DATA, 8'(i * 17));
        host_u.stop_burst();
        `CHK(hold, 1'b1)
        host_u.prep(1'b1, 1'b0);
        for (int i = 1; i < 4; i++)
            rd8(OFS_PROGRAM_LOAD_DATA, 8'(i * 17));
        host_u.prep(1'b0, 1'b1);
        wr8(OFS_PROGRAM_LOAD_DATA, 8'hFF);
        host_u.prep(1'b1, 1'b1);
        rd8(OFS_PROGRAM_LOAD_DATA, 8'h01);
        wr8(OFS_LOAD_START_ADDRESS_LOW, 8'h00);
        // ------------------------------------------------------------
        // Valid, invalid, then reload from safe mode
        // ------------------------------------------------------------
        load(1'b0);
        rd8(OFS_LOAD_RESULT_STATUS, 8'h01);
        `CHK({run_mem, safe, par_on}, 3'b101)
        load(1'b1);
        rd8(OFS_LOAD_RESULT_STATUS, STATUS_INVALID);
        rd8(OFS_PROGRAM_LOAD_CONTROL, 8'h10);
        `CHK({run_mem, safe}, 2'b01)
        load(1'b0);
        rd8(OFS_LOAD_RESULT_STATUS, 8'h01);
        `CHK({run_mem, safe}, 2'b10)
        summarize();
    end
endmodule
